//--- hdl/mdfm_pkg.sv
// Constants, register map and state types of the motor driver fault monitor
package mdfm_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0]  CFG_OFS        = 4'h0;
    localparam logic [3:0]  SCALE_OFS      = 4'h4;
    localparam logic [3:0]  STATUS_OFS     = 4'h8;
    localparam logic [31:0] CFG_RST        = 32'h0000_0000;
    localparam logic [4:0]  SCALE_RST      = 5'h00;
    // Status word field positions
    localparam int ST_SHORT_A   = 0;
    localparam int ST_SHORT_B   = 1;
    localparam int ST_LS_A      = 2;
    localparam int ST_LS_B      = 3;
    localparam int ST_HS_A      = 4;
    localparam int ST_HS_B      = 5;
    localparam int ST_OL_A      = 6;
    localparam int ST_OL_B      = 7;
    localparam int ST_WARN      = 8;
    localparam int ST_SHUT      = 9;
    localparam int ST_READBACK  = 16;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS       = 10;
    localparam int SHORT_DLY0_NS = 3200;
    localparam int SHORT_DLY1_NS = 1600;
    localparam int SHORT_DLY2_NS = 1200;
    localparam int SHORT_DLY3_NS = 800;
    localparam logic [8:0] SHORT_DLY0_CYC = 9'((SHORT_DLY0_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [8:0] SHORT_DLY1_CYC = 9'((SHORT_DLY1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [8:0] SHORT_DLY2_CYC = 9'((SHORT_DLY2_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [8:0] SHORT_DLY3_CYC = 9'((SHORT_DLY3_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0] SHORT_RETRIES  = 2'h3;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [17:0] spare;
        logic [2:0]  highGateSlope;
        logic [3:0]  offTimeSetting;
        logic        lowSupplyMode;
        logic        shutdownThresholdSel;
        logic        lowSideShortEnable;
        logic        shortProtectOff;
        logic [1:0]  shortDelaySel;
        logic        highSideSenseBoost;
    } mdfm_cfg_t;

    typedef struct packed {
        logic [1:0] hsCmpLow;
        logic [1:0] hsCmpHigh;
        logic [1:0] lsCmp;
        logic [1:0] chopEvent;
        logic [1:0] coilPolarity;
        logic [1:0] currentBelowSixteenth;
        logic       tempWarn;
        logic       tempAboveRelease;
        logic       tempAbove136;
        logic       tempAbove150;
        logic       supplyBelow7;
        logic       supplyBelow45;
    } mdfm_sense_t;

    typedef struct packed {
        mdfm_cfg_t       cfg;
        logic [4:0]      currentScale;
        logic [1:0][8:0] hsCnt;
        logic [1:0][8:0] lsCnt;
        logic [1:0][1:0] retry;
        logic [1:0]      hsFlag;
        logic [1:0]      lsFlag;
        logic [1:0]      bridgeOff;
        logic [1:0]      olSeen;
        logic [1:0]      olFlag;
        logic [1:0]      polPrev;
        logic            warnFlag;
        logic            shutFlag;
        logic            thermalOff;
        logic            waitReq;
        logic [31:0]     rdData;
        logic [1:0]      bridgeEn;
        logic [2:0]      slopeOut;
        logic            drvOn;
    } mdfm_state_t;

    localparam mdfm_state_t STATE_RST = '{cfg: CFG_RST, currentScale: SCALE_RST,
                                          waitReq: 1'b1, default: '0};
endpackage : mdfm_pkg

//--- hdl/mdfm_top.sv
// Fault supervision logic of a stepper driver with Avalon-MM register access
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns

module mdfm_top
    import mdfm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire mdfm_sense_t sense,
    input  wire logic        driverDisableIn,
    output logic [1:0]       bridgeEnable,
    output logic [2:0]       gateSlopeHigh,
    output logic             driverOn
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [8:0] dlyCycles(input logic [1:0] sel);
        unique case (sel)
            2'h0: dlyCycles = SHORT_DLY0_CYC;
            2'h1: dlyCycles = SHORT_DLY1_CYC;
            2'h2: dlyCycles = SHORT_DLY2_CYC;
            2'h3: dlyCycles = SHORT_DLY3_CYC;
        endcase
    endfunction : dlyCycles

    function automatic logic [31:0] statusWord(input mdfm_state_t s);
        logic [31:0] w;
        w = '0;
        w[ST_SHORT_A]  = s.hsFlag[0] | s.lsFlag[0];
        w[ST_SHORT_B]  = s.hsFlag[1] | s.lsFlag[1];
        w[ST_LS_A]     = s.lsFlag[0];
        w[ST_LS_B]     = s.lsFlag[1];
        w[ST_HS_A]     = s.hsFlag[0];
        w[ST_HS_B]     = s.hsFlag[1];
        w[ST_OL_A]     = s.olFlag[0];
        w[ST_OL_B]     = s.olFlag[1];
        w[ST_WARN]     = s.warnFlag;
        w[ST_SHUT]     = s.shutFlag;
        w[ST_READBACK +: 5] = s.currentScale;
        statusWord = w;
    endfunction : statusWord

    mdfm_state_t st_reg;
    mdfm_state_t st_next;
    logic        uvActive;
    logic        extDisable;
    logic        mosOff;
    logic        busReq;
    logic [1:0]  hsCmp;
    logic [1:0]  hsEvent;
    logic [1:0]  lsEvent;
    logic [8:0]  dly;

    assign uvActive   = st_reg.cfg.lowSupplyMode ? sense.supplyBelow45 : sense.supplyBelow7;
    assign extDisable = driverDisableIn | (st_reg.cfg.offTimeSetting == 4'h0);
    assign mosOff     = extDisable | st_reg.thermalOff;
    assign busReq     = read | write;
    assign dly        = dlyCycles(st_reg.cfg.shortDelaySel);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        hsCmp   = '0;
        hsEvent = '0;
        lsEvent = '0;
        // Bus slave: one wait cycle, access done while waitrequest low
        st_next.waitReq = !(busReq && st_reg.waitReq);
        if (busReq && st_reg.waitReq) begin
            unique case (address)
                CFG_OFS:    st_next.rdData = st_reg.cfg;
                SCALE_OFS:  st_next.rdData = {27'h0, st_reg.currentScale};
                STATUS_OFS: st_next.rdData = statusWord(st_reg);
                default:    st_next.rdData = 32'h0;
            endcase
        end
        if (write && !st_reg.waitReq) begin
            if (address == CFG_OFS) begin
                st_next.cfg = mdfm_cfg_t'(writedata);
            end
            if (address == SCALE_OFS) begin
                st_next.currentScale = writedata[4:0];
            end
        end

        // Short detection per coil
        for (int c = 0; c < 2; c++) begin
            hsCmp[c] = st_reg.cfg.highSideSenseBoost ? sense.hsCmpHigh[c] : sense.hsCmpLow[c];
            if (hsCmp[c] && !st_reg.cfg.shortProtectOff && st_reg.drvOn
                && !st_reg.bridgeOff[c]) begin
                st_next.hsCnt[c] = st_reg.hsCnt[c] + 9'h1;
                if (st_next.hsCnt[c] >= dly) begin
                    hsEvent[c]       = 1'b1;
                    st_next.hsCnt[c] = '0;
                end
            end else begin
                st_next.hsCnt[c] = '0;
            end
            if (sense.lsCmp[c] && st_reg.cfg.lowSideShortEnable && st_reg.drvOn
                && !st_reg.bridgeOff[c]) begin
                st_next.lsCnt[c] = st_reg.lsCnt[c] + 9'h1;
                if (st_next.lsCnt[c] >= dly) begin
                    lsEvent[c]       = 1'b1;
                    st_next.lsCnt[c] = '0;
                end
            end else begin
                st_next.lsCnt[c] = '0;
            end
            if (hsEvent[c] || lsEvent[c]) begin
                if (st_reg.retry[c] == SHORT_RETRIES) begin
                    // flag source and switch off bridge
                    st_next.hsFlag[c]    = st_reg.hsFlag[c] | hsEvent[c];
                    st_next.lsFlag[c]    = st_reg.lsFlag[c] | lsEvent[c];
                    st_next.bridgeOff[c] = 1'b1;
                end else begin
                    st_next.retry[c] = st_reg.retry[c] + 2'h1;
                end
            end
            if (mosOff) begin
                st_next.hsFlag[c]    = 1'b0;
                st_next.lsFlag[c]    = 1'b0;
                st_next.bridgeOff[c] = 1'b0;
                st_next.retry[c]     = '0;
                st_next.hsCnt[c]     = '0;
                st_next.lsCnt[c]     = '0;
            end

            st_next.polPrev[c] = sense.coilPolarity[c];
            if (sense.coilPolarity[c] != st_reg.polPrev[c]) begin
                if (!sense.currentBelowSixteenth[c]) begin
                    st_next.olFlag[c] = !st_reg.olSeen[c];
                end
                st_next.olSeen[c] = sense.chopEvent[c];
            end else if (sense.chopEvent[c]) begin
                st_next.olSeen[c] = 1'b1;
            end
        end

        st_next.warnFlag = sense.tempWarn;
        if (st_reg.cfg.shutdownThresholdSel ? sense.tempAbove136 : sense.tempAbove150) begin
            st_next.thermalOff = 1'b1;
            st_next.shutFlag   = 1'b1;
        end else if (!sense.tempAboveRelease) begin
            st_next.thermalOff = 1'b0;
            st_next.shutFlag   = 1'b0;
        end

        st_next.slopeOut = st_reg.cfg.highGateSlope;
        if (st_reg.cfg.highGateSlope != 3'h0 && st_reg.cfg.highGateSlope != 3'h7
            && st_next.warnFlag) begin
            st_next.slopeOut = st_reg.cfg.highGateSlope + 3'h1;
        end

        st_next.drvOn    = !extDisable && !st_next.thermalOff;
        st_next.bridgeEn = {2{st_next.drvOn}} & ~st_next.bridgeOff;

        if (uvActive) begin
            st_next = STATE_RST;
        end
        if (!ce) begin
            st_next = st_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign readdata      = st_reg.rdData;
    assign waitrequest   = st_reg.waitReq;
    assign bridgeEnable  = st_reg.bridgeEn;
    assign gateSlopeHigh = st_reg.slopeOut;
    assign driverOn      = st_reg.drvOn;

    // ****************************************
    // Checks
    // ****************************************
    a_retry_limit:
    assert property (@(posedge clk) disable iff (rst)
        $rose(st_reg.hsFlag[0] | st_reg.lsFlag[0]) |-> $past(st_reg.retry[0]) == 2'h3)
        else $error("short confirmed before three retries");
    a_low_gate:
    assert property (@(posedge clk) disable iff (rst)
        $rose(st_reg.lsFlag[1]) |-> $past(st_reg.cfg.lowSideShortEnable))
        else $error("low-side flag set while detection disabled");
    a_high_gate:
    assert property (@(posedge clk) disable iff (rst)
        $rose(st_reg.hsFlag[0]) |-> !$past(st_reg.cfg.shortProtectOff))
        else $error("high-side flag set while protection off");
    a_flags_clear:
    assert property (@(posedge clk) disable iff (rst)
        ce && mosOff |=> st_reg.hsFlag == 2'h0 && st_reg.lsFlag == 2'h0
                         && st_reg.retry[0] == 2'h0)
        else $error("short state kept with MOSFETs disabled");
    a_bridge_off:
    assert property (@(posedge clk) disable iff (rst)
        (st_reg.hsFlag[1] | st_reg.lsFlag[1]) |-> !bridgeEnable[1])
        else $error("bridge driven after confirmed short");
    a_thermal_hold:
    assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.thermalOff && sense.tempAboveRelease |=> st_reg.thermalOff && !driverOn)
        else $error("driver released above release level");
    a_uv_clear:
    assert property (@(posedge clk) disable iff (rst)
        ce && uvActive |=> st_reg.currentScale == 5'h0 && st_reg.cfg == CFG_RST
                           && bridgeEnable == 2'h0)
        else $error("undervoltage did not clear state");
    a_bus_answer:
    assert property (@(posedge clk) disable iff (rst)
        ce && busReq && waitrequest |=> !waitrequest ##1 (waitrequest || !ce))
        else $error("bus answer timing wrong");
endmodule : mdfm_top

//--- dv/mdfm_bridge_model.sv
// Bridge detector model: a shorted bridge trips its comparator only while driven
`timescale 1ns/1ns
module mdfm_bridge_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] bridgeEnable,
    input  wire logic       driverOn,
    input  wire logic [1:0] hsShortReq,
    input  wire logic [1:0] lsShortReq,
    output logic      [1:0] hsCmp,
    output logic      [1:0] lsCmp
);
    // ****************************************
    // Detector outputs
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hsCmp <= 2'h0;
            lsCmp <= 2'h0;
        end else begin
            hsCmp <= hsShortReq & bridgeEnable & {2{driverOn}};
            lsCmp <= lsShortReq & bridgeEnable & {2{driverOn}};
        end
    end
endmodule : mdfm_bridge_model

//--- dv/mdfm_top_tb.sv
// Self-checking bench of the motor driver fault monitor
`timescale 1ns/1ns
module mdfm_top_tb
    import mdfm_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic        driverDisableIn = 1'b0;
    logic [3:0]  address = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    mdfm_sense_t sense;
    logic [1:0]  bridgeEnable;
    logic [1:0]  hsReq = 2'h0;
    logic [1:0]  lsReq = 2'h0;
    logic [1:0]  hsCmp;
    logic [1:0]  lsCmp;
    logic [2:0]  gateSlopeHigh;
    logic        driverOn;
    logic [3:0]  temps = 4'h0;
    logic [1:0]  supply = 2'h0;
    logic        ce = 1'b1;
    logic [1:0]  softShort = 2'h0;
    logic [1:0]  chop = 2'h3;
    logic [1:0]  pol = 2'h0;
    logic [1:0]  low16 = 2'h0;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          total_checks = 0;

    // ****************************************
    // Environment
    // ****************************************
    // Low-sensitivity detector misses a soft short
    assign sense = mdfm_sense_t'({hsCmp & ~softShort, hsCmp, lsCmp, chop, pol, low16,
                                  temps, supply});
    always #5 clk = ~clk;

    mdfm_top dut (.clk(clk), .rst(rst), .ce(ce), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .sense(sense), .driverDisableIn(driverDisableIn),
        .bridgeEnable(bridgeEnable), .gateSlopeHigh(gateSlopeHigh), .driverOn(driverOn));
    mdfm_bridge_model partner (.clk(clk), .rst(rst), .bridgeEnable(bridgeEnable),
        .driverOn(driverOn), .hsShortReq(hsReq), .lsShortReq(lsReq),
        .hsCmp(hsCmp), .lsCmp(lsCmp));

    // ****************************************
    // Shared tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
        if (n >= 100) n_mismatch++;
    endtask : bus
    task give_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // ****************************************
    // Scenarios
    // ****************************************
    task regs;
        bus(1'b0, CFG_OFS, 32'h0);
        chk(rd, CFG_RST);
        chk(driverOn, 1'b0);
        bus(1'b1, CFG_OFS, 32'h1234_5696);
        bus(1'b0, CFG_OFS, 32'h0);
        chk(rd, 32'h1234_5696);
        bus(1'b1, STATUS_OFS, 32'hffff_ffff);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h0);
        $display("test regs done");
    endtask : regs
    task short_case(input logic [31:0] cfg, input logic ls, input int c,
                    input logic expBr, input logic [31:0] expSt);
        bus(1'b1, CFG_OFS, cfg);
        cyc(3);
        if (ls) lsReq[c] <= 1'b1;
        else hsReq[c] <= 1'b1;
        cyc(300);
        chk(bridgeEnable[c], 1'b1);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd & 32'h3ff, 32'h0);
        cyc(40);
        chk(bridgeEnable[c], expBr);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd & 32'h3ff, expSt);
        driverDisableIn <= 1'b1;
        hsReq <= 2'h0;
        lsReq <= 2'h0;
        cyc(3);
        chk(bridgeEnable, 2'h0);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd & 32'h3ff, 32'h0);
        driverDisableIn <= 1'b0;
        cyc(3);
        $display("test short cfg=%h done", cfg);
    endtask : short_case
    task thermal;
        bus(1'b1, CFG_OFS, 32'h896);
        cyc(3);
        chk(gateSlopeHigh, 3'h1);
        temps <= 4'h8;
        cyc(3);
        chk(driverOn, 1'b1);
        chk(gateSlopeHigh, 3'h2);
        temps <= 4'he;
        cyc(3);
        chk(driverOn, 1'b1);
        temps <= 4'hf;
        cyc(3);
        chk(driverOn, 1'b0);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd & 32'h300, 32'h300);
        temps <= 4'hc;
        cyc(3);
        chk(driverOn, 1'b0);
        temps <= 4'h0;
        cyc(3);
        chk(driverOn, 1'b1);
        bus(1'b1, CFG_OFS, 32'hb6);
        temps <= 4'he;
        cyc(3);
        chk(driverOn, 1'b0);
        temps <= 4'h0;
        cyc(3);
        $display("test thermal done");
    endtask : thermal
    task undervolt;
        bus(1'b1, SCALE_OFS, 32'h0a);
        bus(1'b1, CFG_OFS, 32'hd6);
        supply <= 2'h2;
        cyc(3);
        chk(driverOn, 1'b1);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd[20:16], 5'h0a);
        supply <= 2'h3;
        cyc(1);
        supply <= 2'h0;
        cyc(2);
        chk({driverOn, bridgeEnable}, 3'h0);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd[20:16], 5'h00);
        bus(1'b0, CFG_OFS, 32'h0);
        chk(rd, 32'h0);
        $display("test undervoltage done");
    endtask : undervolt
    task short_delay(input logic [1:0] sel, input int expN);
        int n;
        n = 0;
        bus(1'b1, CFG_OFS, 32'h90 | {29'h0, sel, 1'b0});
        cyc(3);
        hsReq[0] <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (bridgeEnable[0] !== 1'b0 && n < 2000);
        chk(n, expN);
        hsReq <= 2'h0;
        driverDisableIn <= 1'b1;
        cyc(3);
        driverDisableIn <= 1'b0;
        cyc(3);
        $display("test delay sel=%h done", sel);
    endtask : short_delay
    task openload;
        bus(1'b1, CFG_OFS, 32'h96);
        chop <= 2'h1;
        cyc(3);
        pol <= 2'h3;
        cyc(3);
        pol <= 2'h0;
        cyc(3);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd & 32'h3ff, 32'h80);
        chk(bridgeEnable, 2'h3);
        chop <= 2'h3;
        low16 <= 2'h2;
        cyc(3);
        pol <= 2'h3;
        cyc(3);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd & 32'h3ff, 32'h80);
        low16 <= 2'h0;
        pol <= 2'h0;
        cyc(3);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd & 32'h3ff, 32'h0);
        $display("test open-load done");
    endtask : openload
    task freeze;
        ce <= 1'b0;
        driverDisableIn <= 1'b1;
        cyc(3);
        chk(driverOn, 1'b1);
        ce <= 1'b1;
        cyc(3);
        chk(driverOn, 1'b0);
        driverDisableIn <= 1'b0;
        cyc(3);
        $display("test freeze done");
    endtask : freeze

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        regs();
        short_case(32'h96, 1'b0, 0, 1'b0, 32'h11);
        short_case(32'h96, 1'b1, 1, 1'b0, 32'h0a);
        short_case(32'h96, 1'b0, 0, 1'b0, 32'h11);
        short_case(32'h9e, 1'b0, 0, 1'b1, 32'h0);
        short_case(32'h86, 1'b1, 1, 1'b1, 32'h0);
        softShort <= 2'h1;
        short_case(32'h96, 1'b0, 0, 1'b1, 32'h0);
        short_case(32'h97, 1'b0, 0, 1'b0, 32'h11);
        softShort <= 2'h0;
        short_delay(2'h0, 4 * SHORT_DLY0_CYC + 2);
        short_delay(2'h1, 4 * SHORT_DLY1_CYC + 2);
        short_delay(2'h2, 4 * SHORT_DLY2_CYC + 2);
        short_delay(2'h3, 4 * SHORT_DLY3_CYC + 2);
        openload();
        freeze();
        thermal();
        undervolt();
        give_verdict();
    end
    initial begin
        #150000;
        n_mismatch++;
        give_verdict();
    end
endmodule : mdfm_top_tb
